// File: hw/ldfm_fault_manager.sv
// Fault supervision for a boost LED controller with an AXI4-Lite slave
`timescale 1ns/100ps
module ldfm_fault_manager
   import ldfm_pkg::*;
#(
   parameter int LONG_DISABLE_TICKS = LDFM_LONG_DIS_TICKS,
   parameter int BLANK_TICKS        = LDFM_BLANK_TICKS
)(
   // Clock, reset, clock enable
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // Converter side
   input  wire logic        osc_tick,
   input  wire logic        enable_in,
   input  ldfm_fault_t      fault_in,
   output logic             gate_drive_out,
   output logic             sleep_out,
   // Open-drain fault flags
   input  wire logic        primary_fault_flag_i,
   output logic             primary_fault_flag_o,
   output logic             primary_fault_flag_oe,
   output logic             secondary_fault_flag_o,
   output logic             secondary_fault_flag_oe,
   // AXI4-Lite write
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   // ==================================================================
   // Declarations
   logic [15:0]       open_to_q;
   logic              pwr_up_q;
   logic              sleep_q;
   logic              str_latch_q;
   logic              out_latch_q;
   logic              gate_q;
   logic              pri_oe_q;
   logic              sec_oe_q;
   ldfm_open_state_t  open_st_q;
   logic              open_hold;
   logic              open_load;
   logic              open_exp;
   logic              long_exp;
   logic              blank_exp;
   logic              uv;
   logic              startup_hold;
   logic              monitor_active;
   logic              uc;
   logic              ot;
   logic              led_short;
   logic              override;
   logic              pri_rel;
   logic              sec_rel;
   logic              gate_d;
   ldfm_status_t      status;
   logic [3:0]        awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              aw_have_q;
   logic              w_have_q;

   // ==================================================================
   // Fault qualification
   assign uv             = !fault_in.rail_good;
   assign startup_hold   = uv || !enable_in || sleep_q;
   assign monitor_active = blank_exp && !startup_hold;
   assign uc             = monitor_active && fault_in.undercurrent;
   assign ot             = monitor_active && fault_in.overtemp;
   assign led_short      = monitor_active &&
                           (fault_in.ref_short || fault_in.nonref_short);
   assign open_hold      = (open_st_q == LDFM_OPEN_HOLD);
   assign override       = !pri_oe_q && !primary_fault_flag_i;

   // Flag and gate combination
   assign pri_rel = uv || str_latch_q || out_latch_q;
   assign sec_rel = uv || uc || ot || led_short || open_hold ||
                    fault_in.open_string;
   assign gate_d  = enable_in && !sleep_q && !uv && !open_hold &&
                    !fault_in.open_string && !str_latch_q &&
                    !(out_latch_q && !override);

   // ==================================================================
   // Timers
   // Power-up pulse loads the blanking and long disable timers, so both start full
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pwr_up_q <= 1'b1;
      end
      else if (ce)
      begin
         pwr_up_q <= 1'b0;
      end
   end

   ldfm_tick_timer #(.W(LDFM_TIMER_W)) u_blank_timer (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .ce       (ce),
      .load     (startup_hold || pwr_up_q),
      .load_val (LDFM_TIMER_W'(BLANK_TICKS)),
      .tick     (osc_tick),
      .expired  (blank_exp)
   );

   ldfm_tick_timer #(.W(LDFM_TIMER_W)) u_open_timer (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .ce       (ce),
      .load     (open_load),
      .load_val (open_to_q),
      .tick     (osc_tick),
      .expired  (open_exp)
   );

   ldfm_tick_timer #(.W(LDFM_TIMER_W)) u_long_timer (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .ce       (ce),
      .load     (enable_in || pwr_up_q),
      .load_val (LDFM_TIMER_W'(LONG_DISABLE_TICKS)),
      .tick     (osc_tick),
      .expired  (long_exp)
   );

   // ==================================================================
   // Open string retry machine, unblanked
   assign open_load = (open_st_q == LDFM_OPEN_IDLE) && fault_in.open_string &&
                      enable_in && !sleep_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         open_st_q <= LDFM_OPEN_IDLE;
      end
      else if (ce)
      begin
         case (open_st_q)
            LDFM_OPEN_IDLE:
            begin
               if (open_load)
               begin
                  open_st_q <= LDFM_OPEN_HOLD;
               end
            end
            LDFM_OPEN_HOLD:
            begin
               if (!enable_in)
               begin
                  open_st_q <= LDFM_OPEN_IDLE;
               end
               else if (open_exp)
               begin
                  open_st_q <= LDFM_OPEN_IDLE;
               end
            end
            default:
            begin
               open_st_q <= LDFM_OPEN_IDLE;
            end
         endcase
      end
   end

   // ==================================================================
   // Sleep after long enable low
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sleep_q <= 1'b0;
      end
      else if (ce)
      begin
         if (enable_in)
         begin
            sleep_q <= 1'b0;
         end
         else if (long_exp)
         begin
            sleep_q <= 1'b1;
         end
      end
   end

   // ==================================================================
   // Short latches; a new set beats the sleep clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         str_latch_q <= 1'b0;
         out_latch_q <= 1'b0;
      end
      else if (ce)
      begin
         if (monitor_active && fault_in.string_short)
         begin
            str_latch_q <= 1'b1;
         end
         else if (sleep_q)
         begin
            str_latch_q <= 1'b0;
         end
         if (monitor_active && fault_in.output_short)
         begin
            out_latch_q <= 1'b1;
         end
         else if (sleep_q)
         begin
            out_latch_q <= 1'b0;
         end
      end
   end

   // ==================================================================
   // Registered outputs
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         gate_q   <= 1'b0;
         pri_oe_q <= 1'b0;
         sec_oe_q <= 1'b0;
      end
      else if (ce)
      begin
         gate_q   <= gate_d;
         pri_oe_q <= !pri_rel;
         sec_oe_q <= !sec_rel;
      end
   end

   assign gate_drive_out          = gate_q;
   assign sleep_out               = sleep_q;
   assign primary_fault_flag_o    = 1'b0;
   assign primary_fault_flag_oe   = pri_oe_q;
   assign secondary_fault_flag_o  = 1'b0;
   assign secondary_fault_flag_oe = sec_oe_q;

   assign status = '{override_active: override, sec_released: !sec_oe_q,
                     pri_released: !pri_oe_q, gate_on: gate_q, sleep: sleep_q,
                     monitor_active: monitor_active, out_short_latch: out_latch_q,
                     str_short_latch: str_latch_q, led_short: led_short,
                     open_hold: open_hold, overtemp: ot, undercurrent: uc,
                     undervoltage: uv};

   // ==================================================================
   // AXI4-Lite write channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= LDFM_RESP_OKAY;
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         awaddr_q      <= 4'h0;
         wdata_q       <= 32'h0;
         wstrb_q       <= 4'h0;
         open_to_q     <= LDFM_OPEN_TO_RST;
      end
      else if (ce)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awaddr_q      <= s_axi_awaddr;
            aw_have_q     <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            w_have_q     <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (aw_have_q && w_have_q && !s_axi_bvalid)
         begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (ldfm_decode(awaddr_q) == LDFM_SEL_CTRL)
            begin
               s_axi_bresp <= LDFM_RESP_OKAY;
               if (wstrb_q[0])
               begin
                  open_to_q[7:0] <= wdata_q[7:0];
               end
               if (wstrb_q[1])
               begin
                  open_to_q[15:8] <= wdata_q[15:8];
               end
            end
            else
            begin
               s_axi_bresp <= LDFM_RESP_SLVERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ==================================================================
   // AXI4-Lite read channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= LDFM_RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            case (ldfm_decode(s_axi_araddr))
               LDFM_SEL_CTRL:
               begin
                  s_axi_rdata <= {16'h0, open_to_q};
                  s_axi_rresp <= LDFM_RESP_OKAY;
               end
               LDFM_SEL_STATUS:
               begin
                  s_axi_rdata <= {19'h0, status};
                  s_axi_rresp <= LDFM_RESP_OKAY;
               end
               default:
               begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= LDFM_RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ==================================================================
   // Assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_uv_gate_flags: assert property (ce && uv |=> !gate_q && !pri_oe_q && !sec_oe_q)
      else $error("undervoltage did not force gate low and release flags");
   a_rail_gates_out: assert property (ce && !fault_in.rail_good |=> !gate_drive_out)
      else $error("gate active without rail good");
   // Sampled reset in the antecedent keeps the release edge out of the check
   a_blank_quiet: assert property (aresetn && ce && !uv && !monitor_active &&
      !fault_in.open_string && !open_hold |=> sec_oe_q)
      else $error("secondary flag released during blanking");
   a_open_unblanked: assert property (aresetn && ce && open_load |=>
      !gate_q && !sec_oe_q && open_hold)
      else $error("open string not acted on at once");
   a_uc_flag: assert property (ce && uc && !uv |=> !sec_oe_q && pri_oe_q == !$past(pri_rel))
      else $error("undercurrent flag handling wrong");
   a_open_holds: assert property (ce && open_hold && enable_in && !open_exp |=> open_hold)
      else $error("open hold left before time-out");
   a_open_retry: assert property (ce && open_hold && enable_in && open_exp |=> !open_hold)
      else $error("open hold not released at time-out");
   a_short_latch: assert property (ce && monitor_active && fault_in.string_short
      |=> str_latch_q ##1 (str_latch_q || $past(sleep_q)))
      else $error("string short not latched");
   a_short_gate: assert property (ce && str_latch_q |=> !gate_q && !pri_oe_q)
      else $error("string short did not disable gate and release primary");
   a_open_clear: assert property (ce && !enable_in |=> !open_hold)
      else $error("open status not cleared by enable low");
   a_sleep_entry: assert property (ce && !enable_in && long_exp |=> sleep_q && !gate_q)
      else $error("long disable did not enter sleep");

endmodule // ldfm_fault_manager

// File: hw/ldfm_pkg.sv
// Shared constants, types and decode for the LED driver fault manager
package ldfm_pkg;

   // ==================================================================
   // Register map, reset values and response codes
   localparam logic [3:0]  LDFM_CTRL_OFS     = 4'h0;
   localparam logic [3:0]  LDFM_STATUS_OFS   = 4'h4;
   localparam logic [15:0] LDFM_OPEN_TO_RST  = 16'h0400;
   localparam logic [1:0]  LDFM_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  LDFM_RESP_SLVERR  = 2'h2;

   // ==================================================================
   // Timing counts, in oscillator periods, and the timer width in bits
   localparam int LDFM_LONG_DIS_TICKS = 32768;
   localparam int LDFM_BLANK_TICKS    = 256;
   localparam int LDFM_TIMER_W        = 16;

   // ==================================================================
   // Types
   typedef struct packed {
      logic rail_good;
      logic undercurrent;
      logic overtemp;
      logic open_string;
      logic ref_short;
      logic nonref_short;
      logic string_short;
      logic output_short;
   } ldfm_fault_t;

   typedef struct packed {
      logic override_active;
      logic sec_released;
      logic pri_released;
      logic gate_on;
      logic sleep;
      logic monitor_active;
      logic out_short_latch;
      logic str_short_latch;
      logic led_short;
      logic open_hold;
      logic overtemp;
      logic undercurrent;
      logic undervoltage;
   } ldfm_status_t;

   typedef enum {LDFM_SEL_CTRL, LDFM_SEL_STATUS, LDFM_SEL_NONE} ldfm_sel_t;

   typedef enum {LDFM_OPEN_IDLE, LDFM_OPEN_HOLD} ldfm_open_state_t;

   // ==================================================================
   // Address decode, shared by read and write paths
   function automatic ldfm_sel_t ldfm_decode(input logic [3:0] addr);
      ldfm_sel_t sel;
      sel = LDFM_SEL_NONE;
      if (addr == LDFM_CTRL_OFS)
      begin
         sel = LDFM_SEL_CTRL;
      end
      else if (addr == LDFM_STATUS_OFS)
      begin
         sel = LDFM_SEL_STATUS;
      end
      return sel;
   endfunction

endpackage

// File: hw/ldfm_tick_timer.sv
// Down-counter of oscillator periods with load and expiry
`timescale 1ns/100ps
module ldfm_tick_timer
   import ldfm_pkg::*;
#(
   parameter int W = LDFM_TIMER_W
)(
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         ce,
   // Control
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   input  wire logic         tick,
   // Status
   output logic              expired
);

   logic [W-1:0] cnt_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_q <= '0;
      end
      else if (ce)
      begin
         if (load)
         begin
            cnt_q <= load_val;
         end
         else if (tick && (cnt_q != '0))
         begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

   // A load in progress is never reported as expiry
   assign expired = (cnt_q == '0) && !load;

endmodule // ldfm_tick_timer

// File: verification/ldfm_flag_monitor.sv
// External monitor with pull-ups on both open-drain fault flags
`timescale 1ns/100ps
module ldfm_flag_monitor
(
   // Flag pins of the design
   input  wire logic pri_o,
   input  wire logic pri_oe,
   input  wire logic sec_o,
   input  wire logic sec_oe,
   // Override request from the bench
   input  wire logic hold_low,
   // Wire levels
   output logic      pri_level,
   output logic      sec_level
);
   // A released flag floats up to the pull-up; the override sinks the primary wire
   assign pri_level = (pri_oe ? pri_o : 1'b1) & ~hold_low;
   assign sec_level = sec_oe ? sec_o : 1'b1;
endmodule // ldfm_flag_monitor

// File: verification/ldfm_fault_manager_tb.sv
// Self-checking bench for the LED driver fault manager
`timescale 1ns/100ps
module ldfm_fault_manager_tb
   import ldfm_pkg::*;
;
   typedef struct {string n; logic [33:0] e; logic [33:0] m;} ldfm_note_t;
   logic        aclk, aresetn, ce, osc_tick, enable_in, hold_low;
   ldfm_fault_t fault_in;
   logic        gate, sleep_s, pri_i, pri_o, pri_oe, sec_o, sec_oe, sec_lvl;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   ldfm_note_t  exp_q[$];
   int          n_fail, check_count, cyc;
   int          sec_bits[4] = '{6, 5, 3, 2};
   logic [15:0] to;
   event        pin_ev;

   ldfm_fault_manager #(.LONG_DISABLE_TICKS(8), .BLANK_TICKS(4)) ldfm_fault_manager_i (
      .aclk(aclk), .aresetn(aresetn), .ce(ce), .osc_tick(osc_tick), .enable_in(enable_in),
      .fault_in(fault_in), .gate_drive_out(gate), .sleep_out(sleep_s),
      .primary_fault_flag_i(pri_i), .primary_fault_flag_o(pri_o),
      .primary_fault_flag_oe(pri_oe), .secondary_fault_flag_o(sec_o),
      .secondary_fault_flag_oe(sec_oe), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   ldfm_flag_monitor ldfm_flag_monitor_i (
      .pri_o(pri_o), .pri_oe(pri_oe), .sec_o(sec_o), .sec_oe(sec_oe),
      .hold_low(hold_low), .pri_level(pri_i), .sec_level(sec_lvl));

   // ==================================================================
   // Clock, oscillator tick every second cycle, timeout
   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   always @(posedge aclk) osc_tick <= ~osc_tick;

   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         n_fail++;
         test_done();
      end
   end

   // ==================================================================
   // Watcher: oldest note against each result
   task automatic compare(input logic [33:0] seen);
      ldfm_note_t x;
      begin
         x = exp_q.pop_front();
         check_count++;
         if ((seen & x.m) !== (x.e & x.m))
         begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", x.n, x.e & x.m, seen & x.m);
         end
      end
   endtask

   always @(negedge aclk)
   begin
      if (rvalid && rready)
         compare({rresp, rdata});
      if (bvalid && bready)
         compare({bresp, 32'h0});
   end

   always @(pin_ev) compare({30'h0, gate, sleep_s, pri_i, sec_lvl});

   // ==================================================================
   // Driver tasks
   task automatic step(input int k);
      repeat (k) @(posedge aclk);
   endtask

   // Expected order: gate, sleep, primary level, secondary level
   task automatic pins(input string n, input logic [3:0] e, input logic [3:0] m);
      begin
         @(negedge aclk);
         exp_q.push_back('{n, {30'h0, e}, {30'h0, m}});
         -> pin_ev;
         @(posedge aclk);
      end
   endtask

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw_hs, w_hs, b_hs;
      begin
         exp_q.push_back('{"bresp", {r, 32'h0}, 34'h3_0000_0000});
         awaddr  <= a;
         wdata   <= d;
         awvalid <= 1'b1;
         wvalid  <= 1'b1;
         b_hs = 1'b0;
         while (!b_hs)
         begin
            @(negedge aclk);
            aw_hs = awvalid && awready;
            w_hs  = wvalid && wready;
            b_hs  = bvalid && bready;
            @(posedge aclk);
            if (aw_hs)
               awvalid <= 1'b0;
            if (w_hs)
               wvalid <= 1'b0;
         end
      end
   endtask

   task automatic axi_rd(input logic [3:0] a, input logic [33:0] e, input logic [33:0] m,
                         input string n);
      logic ar_hs, r_hs;
      begin
         exp_q.push_back('{n, e, m});
         araddr  <= a;
         arvalid <= 1'b1;
         r_hs = 1'b0;
         while (!r_hs)
         begin
            @(negedge aclk);
            ar_hs = arvalid && arready;
            r_hs  = rvalid && rready;
            @(posedge aclk);
            if (ar_hs)
               arvalid <= 1'b0;
         end
      end
   endtask

   task automatic st(input int b, input logic v, input string n);
      axi_rd(LDFM_STATUS_OFS, {LDFM_RESP_OKAY, 32'(v) << b}, {2'h3, 32'h1 << b}, n);
   endtask

   task automatic do_reset(input logic [7:0] f);
      begin
         aresetn  <= 1'b0;
         fault_in <= ldfm_fault_t'(f);
         repeat (12) @(posedge aclk);
         aresetn  <= 1'b1;
      end
   endtask

   task test_done;
      begin
         $display("Checks %0d, mismatches %0d", check_count, n_fail);
         if (n_fail == 0 && check_count > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask

   // ==================================================================
   // Main sequence
   initial
   begin
      {aresetn, osc_tick, hold_low, awvalid, wvalid, arvalid} = '0;
      {ce, enable_in, bready, rready} = 4'hF;
      fault_in = ldfm_fault_t'(8'h00);
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      {n_fail, check_count, cyc} = '0;
      void'($urandom(32'h49EF));
      @(posedge aclk);
      do_reset(8'hC0);
      step(2);
      pins("blank_sec", 4'b0000, 4'b0001);
      step(30);
      pins("unblank_sec", 4'b1001, 4'hF);
      foreach (sec_bits[i])
      begin
         fault_in <= ldfm_fault_t'(8'h80 | (8'h01 << sec_bits[i]));
         step(3);
         pins("sec_fault", 4'b1001, 4'hF);
         fault_in <= ldfm_fault_t'(8'h80);
         step(3);
         pins("sec_clear", 4'b1000, 4'hF);
      end
      axi_rd(LDFM_CTRL_OFS, {LDFM_RESP_OKAY, 16'h0, LDFM_OPEN_TO_RST}, {2'h3, 32'hFFFF},
             "ctrl_rst");
      to = 16'(4 + ($urandom % 8));
      axi_wr(LDFM_CTRL_OFS, {16'($urandom), to}, LDFM_RESP_OKAY);
      axi_rd(LDFM_CTRL_OFS, {LDFM_RESP_OKAY, 16'h0, to}, {2'h3, 32'hFFFF}, "ctrl_to");
      axi_wr(LDFM_STATUS_OFS, 32'hFFFF_FFFF, LDFM_RESP_SLVERR);
      axi_rd(4'h8, {LDFM_RESP_SLVERR, 32'h0}, {2'h3, 32'hFFFF_FFFF}, "unmapped");
      fault_in <= ldfm_fault_t'(8'h00);
      step(3);
      pins("uv", 4'b0011, 4'hF);
      fault_in <= ldfm_fault_t'(8'h80);
      step(30);
      pins("uv_back", 4'b1000, 4'hF);
      fault_in <= ldfm_fault_t'(8'h90);
      step(2);
      pins("open", 4'b0001, 4'b1011);
      st(3, 1'b1, "open_hold");
      step(2 * to + 10);
      pins("open_retry", 4'b0001, 4'b1011);
      fault_in <= ldfm_fault_t'(8'h80);
      step(2 * to + 10);
      pins("open_done", 4'b1000, 4'hF);
      fault_in <= ldfm_fault_t'(8'h81);
      step(3);
      pins("oshort", 4'b0010, 4'b1011);
      hold_low <= 1'b1;
      step(3);
      pins("override", 4'b1000, 4'b1010);
      fault_in <= ldfm_fault_t'(8'h80);
      step(3);
      st(6, 1'b1, "oshort_latch");
      hold_low <= 1'b0;
      step(3);
      pins("latched", 4'b0010, 4'b1011);
      ce        <= 1'b0;
      enable_in <= 1'b0;
      step(40);
      pins("frozen", 4'b0010, 4'hF);
      ce        <= 1'b1;
      enable_in <= 1'b0;
      step(4);
      enable_in <= 1'b1;
      step(30);
      pins("short_en", 4'b0010, 4'b1011);
      enable_in <= 1'b0;
      step(40);
      pins("sleep", 4'b0100, 4'b0100);
      enable_in <= 1'b1;
      step(30);
      pins("woken", 4'b1000, 4'hF);
      fault_in <= ldfm_fault_t'(8'h82);
      step(3);
      fault_in <= ldfm_fault_t'(8'h80);
      hold_low <= 1'b1;
      step(3);
      pins("sshort_ovr", 4'b0000, 4'b1000);
      hold_low <= 1'b0;
      step(2);
      pins("sshort", 4'b0010, 4'b1011);
      do_reset(8'h90);
      step(2);
      pins("open_start", 4'b0001, 4'b1011);
      test_done();
   end
endmodule // ldfm_fault_manager_tb
